// ### shared/timer_pkg.sv
// constants, field layouts and bus carrier of the sixteen bit interval timer
// assumes a single 125 mhz system clock and a plain strobe register port
`default_nettype none

package timer_pkg;

    // ------------------------------------------------------------------
    // clock and widths
    // ------------------------------------------------------------------
    localparam int          SYS_CLK_MHZ  = 125;
    localparam int          CNT_W        = 16;
    localparam int          ADDR_W       = 4;
    localparam int          PRE_W        = 8;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0]  OFS_CONTROL  = 4'h0;
    localparam logic [3:0]  OFS_COUNT    = 4'h1;
    localparam logic [3:0]  OFS_PERIOD   = 4'h2;
    localparam logic [3:0]  OFS_STATUS   = 4'h3;
    localparam logic [3:0]  OFS_MASK     = 4'h4;
    localparam logic [3:0]  OFS_PRIORITY = 4'h5;

    // ------------------------------------------------------------------
    // control register field positions and reset values
    // ------------------------------------------------------------------
    localparam int          BIT_RUN      = 15;
    localparam int          BIT_IDLE     = 13;
    localparam int          BIT_GATE     = 6;
    localparam int          BIT_PRE_HI   = 5;
    localparam int          BIT_PRE_LO   = 4;
    localparam int          BIT_SYNC     = 2;
    localparam int          BIT_SRC      = 1;
    localparam logic [15:0] CTRL_IMPL    = 16'ha076;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;

    // ------------------------------------------------------------------
    // interrupt status layout and prescale ratios (terminal count = ratio - 1)
    // ------------------------------------------------------------------
    localparam int          IRQ_N        = 2;
    localparam int          IRQ_MATCH    = 0;
    localparam int          IRQ_GATE     = 1;
    localparam int          PRIO_W       = 3;
    localparam logic [7:0]  PRE_TC_1     = 8'h00;
    localparam logic [7:0]  PRE_TC_8     = 8'h07;
    localparam logic [7:0]  PRE_TC_64    = 8'h3f;
    localparam logic [7:0]  PRE_TC_256   = 8'hff;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CNT_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } bus_req_s;

endpackage : timer_pkg

`default_nettype wire

// ### design/sixteen_bit_interval_timer.sv
// sixteen bit interval timer / counter with prescaler, gate and period match
// assumes pins are synchronous to sys_clk and a single-cycle strobe bus master
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`default_nettype none

// Notes on behaviour
// - one 16-bit count: timer, synchronised counter or unsynchronised pulse counter
// - usable as time base for a real-time clock or free-running interval timer
// - counting continues through idle and sleep unless idle halt is set
// - interrupt request on period match and on gate falling edge in gate mode
// - run bit 15 starts counting when one, stops when zero
// - bit 13 set halts timer in idle; clear keeps it running
// - gate bit 6 ignored with the external clock selected
// - control bits 14, 12-7, 3, 0 read zero, writes dropped
// - sync bit picks synchronised or direct counting of external edges
// - interrupt forwarded only when enabled; three-bit priority held for software
// - selected count clock divided by prescaler before advancing the count
// - prescale field: 00 by 1, 01 by 8, 10 by 64, 11 by 256
// - bit 1 one counts external rising edges, zero counts half system clock
// - bit 2 synchronises external input only when external clock selected
// - gate mode counts internal clock only while gate input is high

module sixteen_bit_interval_timer (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    input  wire timer_pkg::bus_req_s         bus_req,
    output var  logic [timer_pkg::CNT_W-1:0] rd_data_r,
    input  wire logic                        idle_mode,
    input  wire logic                        ext_count_clock_pin,
    input  wire logic                        gate_in,
    output var  logic                        timer_irq_r,
    output var  logic [timer_pkg::PRIO_W-1:0] timer_irq_priority_r
);
    import timer_pkg::*;

    logic [CNT_W-1:0]  control_r;
    logic [CNT_W-1:0]  count_r;
    logic [CNT_W-1:0]  count_nxt;
    logic [CNT_W-1:0]  period_value_r;
    logic [IRQ_N-1:0]  status_r;
    logic [IRQ_N-1:0]  mask_r;
    logic [IRQ_N-1:0]  event_set;
    logic [PRE_W-1:0]  pre_cnt_r;
    logic [PRE_W-1:0]  pre_tc;
    logic              half_r;
    logic              ext_meta_r;
    logic              ext_sync_r;
    logic              ext_sync_d_r;
    logic              ext_raw_d_r;
    logic              gate_d_r;
    logic              timer_run;
    logic              idle_halt;
    logic              gate_accumulate;
    logic [1:0]        prescale_select;
    logic              ext_clock_synchronise;
    logic              count_clock_source;
    logic              gate_mode;
    logic              active;
    logic              src_tick;
    logic              pre_tick;
    logic              wr_hit_status;

    assign timer_run             = control_r[BIT_RUN];
    assign idle_halt             = control_r[BIT_IDLE];
    assign gate_accumulate       = control_r[BIT_GATE];
    assign prescale_select       = control_r[BIT_PRE_HI:BIT_PRE_LO];
    assign ext_clock_synchronise = control_r[BIT_SYNC];
    assign count_clock_source    = control_r[BIT_SRC];

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // unimplemented control bits are masked off on the way in
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_r <= CTRL_RESET;
        end else if (bus_req.wr && bus_req.addr == OFS_CONTROL) begin
            control_r <= bus_req.wdata & CTRL_IMPL;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_value_r <= PERIOD_RESET;
        end else if (bus_req.wr && bus_req.addr == OFS_PERIOD) begin
            period_value_r <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= '0;
        end else if (bus_req.wr && bus_req.addr == OFS_MASK) begin
            mask_r <= bus_req.wdata[IRQ_N-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq_priority_r <= '0;
        end else if (bus_req.wr && bus_req.addr == OFS_PRIORITY) begin
            timer_irq_priority_r <= bus_req.wdata[PRIO_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------------
    // idle stops the module only when idle halt is set; sleep never stops it
    assign active    = timer_run && !(idle_halt && idle_mode);
    // gating applies only to the internal source
    assign gate_mode = gate_accumulate && !count_clock_source;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_r <= 1'b0;
        end else begin
            half_r <= ~half_r;
        end
    end

    // two-stage synchroniser; the first stage is read only by the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_r   <= 1'b0;
            ext_sync_r   <= 1'b0;
            ext_sync_d_r <= 1'b0;
            ext_raw_d_r  <= 1'b0;
            gate_d_r     <= 1'b0;
        end else begin
            ext_meta_r   <= ext_count_clock_pin;
            ext_sync_r   <= ext_meta_r;
            ext_sync_d_r <= ext_sync_r;
            ext_raw_d_r  <= ext_count_clock_pin;
            gate_d_r     <= gate_in;
        end
    end

    // direct path trades metastability margin for two cycles less latency
    always_comb begin
        if (count_clock_source) begin
            if (ext_clock_synchronise) begin
                src_tick = ext_sync_r && !ext_sync_d_r;
            end else begin
                src_tick = ext_count_clock_pin && !ext_raw_d_r;
            end
        end else begin
            src_tick = half_r && (!gate_mode || gate_in);
        end
    end

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    always_comb begin
        unique case (prescale_select)
            2'b00: pre_tc = PRE_TC_1;
            2'b01: pre_tc = PRE_TC_8;
            2'b10: pre_tc = PRE_TC_64;
            2'b11: pre_tc = PRE_TC_256;
        endcase
    end

    assign pre_tick = active && src_tick && (pre_cnt_r == pre_tc);

    // cleared while stopped so every run starts with a full prescale period
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_r <= '0;
        end else if (!timer_run) begin
            pre_cnt_r <= '0;
        end else if (active && src_tick) begin
            pre_cnt_r <= pre_tick ? '0 : pre_cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // count and period match
    // ------------------------------------------------------------------
    always_comb begin
        if (count_r == period_value_r) begin
            count_nxt = CNT_RESET;
        end else begin
            count_nxt = count_r + 16'h0001;
        end
    end

    // a software write to the count wins over a tick in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= CNT_RESET;
        end else if (bus_req.wr && bus_req.addr == OFS_COUNT) begin
            count_r <= bus_req.wdata;
        end else if (pre_tick) begin
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, mask and request
    // ------------------------------------------------------------------
    assign event_set[IRQ_MATCH] = pre_tick && (count_nxt == period_value_r);
    assign event_set[IRQ_GATE]  = timer_run && gate_mode && gate_d_r && !gate_in;
    assign wr_hit_status        = bus_req.wr && bus_req.addr == OFS_STATUS;

    // write one to clear; a new event in the same cycle keeps its bit set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~({IRQ_N{wr_hit_status}} & bus_req.wdata[IRQ_N-1:0]))
                        | event_set;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq_r <= 1'b0;
        end else begin
            timer_irq_r <= |(status_r & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= '0;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_CONTROL:  rd_data_r <= control_r & CTRL_IMPL;
                OFS_COUNT:    rd_data_r <= count_r;
                OFS_PERIOD:   rd_data_r <= period_value_r;
                OFS_STATUS:   rd_data_r <= {{(CNT_W-IRQ_N){1'b0}}, status_r};
                OFS_MASK:     rd_data_r <= {{(CNT_W-IRQ_N){1'b0}}, mask_r};
                OFS_PRIORITY: rd_data_r <= {{(CNT_W-PRIO_W){1'b0}}, timer_irq_priority_r};
                default:      rd_data_r <= '0;
            endcase
        end else begin
            rd_data_r <= '0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    ctrl_zero_bits_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (control_r & ~CTRL_IMPL) == 16'h0000)
        else $error("unimplemented control bit set");

    stopped_holds_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!timer_run && !(bus_req.wr && bus_req.addr == OFS_COUNT)) |=> $stable(count_r))
        else $error("count moved while stopped");

    idle_halts_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (idle_halt && idle_mode && !(bus_req.wr && bus_req.addr == OFS_COUNT))
        |=> $stable(count_r))
        else $error("count moved in idle with halt set");

    // one step per two clocks, so compare across two samples; period zero never moves
    idle_runs_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (timer_run && !idle_halt && !count_clock_source && !gate_accumulate
         && prescale_select == 2'b00 && period_value_r != 16'h0000) [*4]
        |-> count_r != $past(count_r, 2) || $past(bus_req.wr) || $past(bus_req.wr, 2))
        else $error("internal count stalled");

    gate_ignored_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        count_clock_source |-> !event_set[IRQ_GATE])
        else $error("gate acted with external clock");

    gate_blocks_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (gate_mode && !gate_in) |-> !src_tick)
        else $error("count tick while gate low");

    wrap_zero_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (pre_tick && count_r == period_value_r && !(bus_req.wr && bus_req.addr == OFS_COUNT))
        |=> count_r == CNT_RESET)
        else $error("count did not wrap after match");

    match_flag_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        event_set[IRQ_MATCH] |=> status_r[IRQ_MATCH])
        else $error("match event not latched");

    prescale_div_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        pre_tick |-> pre_cnt_r == pre_tc && pre_tc == (prescale_select == 2'b00 ? PRE_TC_1 :
                     prescale_select == 2'b01 ? PRE_TC_8 :
                     prescale_select == 2'b10 ? PRE_TC_64 : PRE_TC_256))
        else $error("prescaler terminal count wrong");

    half_rate_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!count_clock_source && src_tick) |=> !src_tick)
        else $error("internal clock above half rate");

    irq_masked_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ##1 (timer_irq_r == |($past(status_r) & $past(mask_r))))
        else $error("interrupt not gated by mask");

    gate_flag_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        event_set[IRQ_GATE] |=> status_r[IRQ_GATE])
        else $error("gate fall event not latched");

    status_sticky_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (status_r[IRQ_MATCH] && !(wr_hit_status && bus_req.wdata[IRQ_MATCH]))
        |=> status_r[IRQ_MATCH])
        else $error("match flag dropped without a clear");

    count_step_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (pre_tick && count_r != period_value_r && !(bus_req.wr && bus_req.addr == OFS_COUNT))
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("count did not advance by one");

    ctrl_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (bus_req.rd && bus_req.addr == OFS_CONTROL)
        |=> (rd_data_r & ~CTRL_IMPL) == 16'h0000)
        else $error("unimplemented control bit read as one");

    pre_clear_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !timer_run |=> pre_cnt_r == 8'h00)
        else $error("prescaler kept a count while stopped");

endmodule : sixteen_bit_interval_timer

`default_nettype wire

// ### dv/sixteen_bit_interval_timer_test.sv
// self-checking bench for the sixteen bit interval timer
// assumes timer_pkg compiled first; drives the strobe register port and pins directly
`default_nettype none

module sixteen_bit_interval_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_pkg::*;

    logic                 sys_clk = 1'b0;
    logic                 rst_n   = 1'b0;
    bus_req_s             bus_req = '0;
    logic [CNT_W-1:0]     rd_data_r;
    logic                 idle_mode = 1'b0;
    logic                 ext_count_clock_pin = 1'b0;
    logic                 gate_in = 1'b0;
    logic                 timer_irq_r;
    logic [PRIO_W-1:0]    timer_irq_priority_r;
    int                   mismatches = 0;
    int                   checked    = 0;
    logic [15:0]          rv;

    sixteen_bit_interval_timer dut (
        .sys_clk              (sys_clk),
        .rst_n                (rst_n),
        .bus_req              (bus_req),
        .rd_data_r            (rd_data_r),
        .idle_mode            (idle_mode),
        .ext_count_clock_pin  (ext_count_clock_pin),
        .gate_in              (gate_in),
        .timer_irq_r          (timer_irq_r),
        .timer_irq_priority_r (timer_irq_priority_r)
    );

    always #4 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------
    // bus cycles and comparisons
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe edge; taken mid-cycle,
    // then back on a rising edge so later stimulus stays edge aligned
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        @(negedge sys_clk);
        d = rd_data_r;
        @(posedge sys_clk);
    endtask : rd

    task automatic check16(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check16

    // phase of the first tick against the bus write is not pinned down, so allow a span
    task automatic check_rng(input string nm, input logic [15:0] lo, input logic [15:0] hi,
                             input logic [15:0] seen);
        checked++;
        if ((seen >= lo && seen <= hi) !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, seen);
        end
    endtask : check_rng

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_clk

    task automatic pulse_pin(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ext_count_clock_pin <= 1'b1;
            wait_clk(4);
            ext_count_clock_pin <= 1'b0;
            wait_clk(4);
        end
    endtask : pulse_pin

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        rd(OFS_CONTROL, rv);  check16("control reset", 16'h0000, rv);
        rd(OFS_COUNT, rv);    check16("count reset", CNT_RESET, rv);
        rd(OFS_PERIOD, rv);   check16("period reset", PERIOD_RESET, rv);
        rd(OFS_STATUS, rv);   check16("status reset", 16'h0000, rv);
        check16("irq at reset", 16'h0000, {15'h0000, timer_irq_r});
    endtask : test_reset

    task automatic test_control_bits();
        wr(OFS_CONTROL, 16'hffff);
        rd(OFS_CONTROL, rv);  check16("control mask", 16'ha076, rv);
        wr(OFS_CONTROL, 16'h5f89);
        rd(OFS_CONTROL, rv);  check16("control holes", 16'h0000, rv);
        wr(4'hf, 16'h1234);
        rd(4'hf, rv);         check16("unmapped read", 16'h0000, rv);
        wr(OFS_PRIORITY, 16'hfffd);
        rd(OFS_PRIORITY, rv); check16("priority reg", 16'h0005, rv);
        check16("priority out", 16'h0005, {13'h0000, timer_irq_priority_r});
    endtask : test_control_bits

    task automatic test_period_match();
        wr(OFS_COUNT, 16'h0000);
        wr(OFS_CONTROL, 16'h8000);
        wr(OFS_PERIOD, 16'h0003);
        wait_clk(40);
        rd(OFS_COUNT, rv);    check_rng("count wraps", 16'h0000, 16'h0003, rv);
        rd(OFS_STATUS, rv);   check16("match flag", 16'h0001, rv);
        wr(OFS_MASK, 16'h0001);
        wait_clk(3);
        @(negedge sys_clk);
        check16("irq unmasked", 16'h0001, {15'h0000, timer_irq_r});
        wr(OFS_MASK, 16'h0000);
        wait_clk(3);
        @(negedge sys_clk);
        check16("irq masked", 16'h0000, {15'h0000, timer_irq_r});
        wr(OFS_CONTROL, 16'h0000);
        wr(OFS_STATUS, 16'h0003);
        wr(OFS_MASK, 16'h0001);
        wait_clk(3);
        rd(OFS_STATUS, rv);   check16("status w1c", 16'h0000, rv);
        @(negedge sys_clk);
        check16("irq cleared", 16'h0000, {15'h0000, timer_irq_r});
        wr(OFS_MASK, 16'h0000);
        wr(OFS_PERIOD, 16'hffff);
    endtask : test_period_match

    task automatic test_prescale();
        int ratio [4] = '{1, 8, 64, 256};
        for (int i = 0; i < 4; i++) begin
            wr(OFS_COUNT, 16'h0000);
            wr(OFS_CONTROL, 16'h8000 | (16'(i) << 4));
            wait_clk(12 * ratio[i]);
            wr(OFS_CONTROL, 16'h0000);
            rd(OFS_COUNT, rv);
            check_rng("prescaled count", 16'h0005, 16'h0007, rv);
        end
    endtask : test_prescale

    task automatic test_run_idle();
        wr(OFS_COUNT, 16'h0005);
        wait_clk(20);
        rd(OFS_COUNT, rv);    check16("stopped count", 16'h0005, rv);
        idle_mode <= 1'b1;
        wr(OFS_COUNT, 16'h0000);
        wr(OFS_CONTROL, 16'h8000);
        wait_clk(20);
        rd(OFS_COUNT, rv);    check_rng("idle runs", 16'h0008, 16'h000c, rv);
        wr(OFS_CONTROL, 16'ha000);
        wr(OFS_COUNT, 16'h0000);
        wait_clk(20);
        rd(OFS_COUNT, rv);    check16("idle halt", 16'h0000, rv);
        idle_mode <= 1'b0;
        wr(OFS_CONTROL, 16'h0000);
    endtask : test_run_idle

    task automatic test_gate();
        wr(OFS_COUNT, 16'h0000);
        wr(OFS_CONTROL, 16'h8040);
        wait_clk(20);
        rd(OFS_COUNT, rv);    check16("gate closed", 16'h0000, rv);
        gate_in <= 1'b1;
        wait_clk(20);
        gate_in <= 1'b0;
        wait_clk(3);
        rd(OFS_COUNT, rv);    check_rng("gate open", 16'h0008, 16'h000b, rv);
        rd(OFS_STATUS, rv);   check16("gate fall flag", 16'h0002, rv);
        wr(OFS_STATUS, 16'h0002);
        // external source: gate bit must not block counting
        wr(OFS_COUNT, 16'h0000);
        wr(OFS_CONTROL, 16'h8046);
        pulse_pin(3);
        wait_clk(6);
        rd(OFS_COUNT, rv);    check16("gate ignored", 16'h0003, rv);
        wr(OFS_CONTROL, 16'h0000);
    endtask : test_gate

    task automatic test_ext_clock();
        logic [15:0] ctl [2] = '{16'h8002, 16'h8006};
        logic [15:0] early [2] = '{16'h0001, 16'h0000};
        for (int i = 0; i < 2; i++) begin
            wr(OFS_COUNT, 16'h0000);
            wr(OFS_CONTROL, ctl[i]);
            // direct path steps on the first high sample, synchronised two cycles later
            ext_count_clock_pin <= 1'b1;
            rd(OFS_COUNT, rv); check16("ext latency", early[i], rv);
            ext_count_clock_pin <= 1'b0;
            pulse_pin(3);
            wait_clk(6);
            rd(OFS_COUNT, rv); check16("ext edges", 16'h0004, rv);
            wr(OFS_CONTROL, 16'h0000);
        end
    endtask : test_ext_clock

    // ------------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        // main sequence needs about 4400 cycles
        wait_clk(40000);
        mismatches++;
        give_verdict();
    end

    initial begin
        wait_clk(8);
        rst_n <= 1'b1;
        test_reset();
        test_control_bits();
        test_period_match();
        test_prescale();
        test_run_idle();
        test_gate();
        test_ext_clock();
        give_verdict();
    end

endmodule : sixteen_bit_interval_timer_test

`default_nettype wire
